// ===== src/smct_table.sv
// database and command-record interpreter of the serial master
`timescale 1ns/1ps
module smct_table
  import smct_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // host (write block / read block) access
  input  wire logic              i_host_wr,
  input  wire logic              i_host_rd,
  input  wire logic [DB_AW-1:0]  i_host_addr,
  input  wire logic [DW-1:0]     i_host_wdata,
  output logic [DW-1:0]          o_host_rdata,
  output logic                   o_host_rvalid,
  output logic                   o_host_err,
  // master command data path (read results in, write payload out)
  input  wire logic              i_link_wr,
  input  wire logic              i_link_rd,
  input  wire logic [DB_AW-1:0]  i_link_addr,
  input  wire logic [DW-1:0]     i_link_wdata,
  output logic [DW-1:0]          o_link_rdata,
  output logic                   o_link_rvalid,
  output logic                   o_link_err,
  // command interpreter
  input  wire logic              i_cmd_start,
  input  wire logic              i_cmd_port,
  input  wire logic [6:0]        i_cmd_index,
  output logic                   o_cmd_busy,
  output logic                   o_cmd_done,
  output logic                   o_cmd_error,
  output logic                   o_cmd_enable,
  output logic [DW-1:0]          o_cmd_db_addr,
  output logic [19:0]            o_cmd_poll_tenths,
  output logic [DW-1:0]          o_cmd_count,
  output logic [DW-1:0]          o_cmd_swap,
  output logic [7:0]             o_cmd_node,
  output logic [DW-1:0]          o_cmd_function_selector,
  output logic [7:0]             o_cmd_command,
  output logic [7:0]             o_cmd_function,
  output logic                   o_cmd_has_function,
  output logic                   o_cmd_ascii_addr,
  output logic [2:0]             o_cmd_param_count,
  output logic [4*DW-1:0]        o_cmd_params
);

  // ****************************************************************
  // region decode
  // ****************************************************************
  function automatic logic is_user(input logic [DB_AW-1:0] a);
    return a <= DB_AW'(USER_LAST);
  endfunction : is_user

  // reserved words never hold data: they refuse writes and read zero
  function automatic logic is_mapped(input logic [DB_AW-1:0] a);
    logic ok;
    ok = 1'b1;
    if (a >= DB_AW'(RSV1_FIRST) && a <= DB_AW'(RSV1_LAST)) ok = 1'b0;
    if (a > DB_AW'(STAT_LAST) && a < DB_AW'(CTRL_FIRST)) ok = 1'b0;
    if (a >= DB_AW'(RSV2_FIRST)) ok = 1'b0;
    return ok;
  endfunction : is_mapped

  logic [DW-1:0] mem [0:DB_WORDS-1];

  // ****************************************************************
  // database writes
  // ****************************************************************
  // host write blocks win the single write port; a colliding link write
  // is refused and flagged so the master can retry it
  logic host_wr_ok;
  logic link_wr_ok;
  assign host_wr_ok = i_host_wr && is_mapped(i_host_addr);
  assign link_wr_ok = i_link_wr && is_user(i_link_addr) && !host_wr_ok;

  always_ff @(posedge i_clk) begin
    if (host_wr_ok) begin
      mem[i_host_addr] <= i_host_wdata;
    end else if (link_wr_ok) begin
      mem[i_link_addr] <= i_link_wdata;
    end
  end

  // ****************************************************************
  // host and link read ports
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_host_rdata  <= 16'h0000;
      o_host_rvalid <= 1'b0;
      o_host_err    <= 1'b0;
    end else begin
      o_host_rvalid <= i_host_rd && !i_host_wr;
      o_host_err    <= (i_host_rd || i_host_wr) && !is_mapped(i_host_addr);
      if (i_host_rd && !i_host_wr) begin
        o_host_rdata <= is_mapped(i_host_addr) ? mem[i_host_addr] : 16'h0000;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_link_rdata  <= 16'h0000;
      o_link_rvalid <= 1'b0;
      o_link_err    <= 1'b0;
    end else begin
      o_link_rvalid <= i_link_rd && !i_link_wr && is_user(i_link_addr);
      o_link_err    <= (i_link_rd && !is_user(i_link_addr)) ||
                       (i_link_wr && !link_wr_ok);
      if (i_link_rd && !i_link_wr && is_user(i_link_addr)) begin
        o_link_rdata <= mem[i_link_addr];
      end
    end
  end

  // ****************************************************************
  // command record fetch
  // ****************************************************************
  typedef enum logic [1:0] {
    SMCT_IDLE   = 2'b00,
    SMCT_FETCH  = 2'b01,
    SMCT_DECODE = 2'b10
  } smct_state_t;

  smct_state_t      state;
  logic [DB_AW-1:0] rec_base;
  logic [3:0]       fetch_ptr;
  logic [DW-1:0]    fetch_data;
  logic [DW-1:0]    rec [0:REC_FIELDS-1];
  logic             index_bad;

  assign index_bad = i_cmd_index >= 7'(REC_COUNT);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state     <= SMCT_IDLE;
      rec_base  <= '0;
      fetch_ptr <= 4'h0;
    end else begin
      case (state)
        SMCT_IDLE: begin
          fetch_ptr <= 4'h0;
          if (i_cmd_start && !index_bad) begin
            state    <= SMCT_FETCH;
            rec_base <= (i_cmd_port ? DB_AW'(P2CMD_FIRST) : DB_AW'(P1CMD_FIRST))
                        + DB_AW'(i_cmd_index) * DB_AW'(REC_WORDS);
          end
        end
        SMCT_FETCH: begin
          fetch_ptr <= fetch_ptr + 4'h1;
          if (fetch_ptr == 4'(REC_FIELDS)) begin
            state <= SMCT_DECODE;
          end
        end
        SMCT_DECODE: state <= SMCT_IDLE;
        default:     state <= SMCT_IDLE;
      endcase
    end
  end

  // word k is addressed at ptr k and captured one cycle later
  always_ff @(posedge i_clk) begin
    fetch_data <= mem[rec_base + DB_AW'(fetch_ptr)];
  end

  genvar g;
  generate
    for (g = 0; g < REC_FIELDS; g++) begin : g_rec
      always_ff @(posedge i_clk) begin
        if (state == SMCT_FETCH && fetch_ptr == 4'(g + 1)) begin
          rec[g] <= fetch_data;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // function code decode
  // ****************************************************************
  logic       dec_known;
  logic       dec_has_fn;
  logic       dec_ascii;
  logic [7:0] dec_cmd;
  logic [7:0] dec_fn;
  logic [2:0] dec_np;

  always_comb begin
    dec_known  = 1'b1;
    dec_has_fn = 1'b1;
    dec_ascii  = 1'b0;
    dec_cmd    = CMD_EXTENDED;
    dec_fn     = 8'h00;
    dec_np     = 3'd3;
    case (rec[F_FUNC])
      16'd1:   begin dec_cmd = CMD_PROT_WR;      dec_has_fn = 1'b0; dec_np = 3'd1; end
      16'd2:   begin dec_cmd = CMD_UNPROT_RD;    dec_has_fn = 1'b0; dec_np = 3'd1; end
      16'd3:   begin dec_cmd = CMD_PROT_BITWR;   dec_has_fn = 1'b0; dec_np = 3'd1; end
      16'd4:   begin dec_cmd = CMD_UNPROT_BITWR; dec_has_fn = 1'b0; dec_np = 3'd1; end
      16'd5:   begin dec_cmd = CMD_UNPROT_WR;    dec_has_fn = 1'b0; dec_np = 3'd1; end
      16'd100: dec_fn = FN_RANGE_WR;
      16'd101: dec_fn = FN_RANGE_RD;
      16'd102: dec_fn = FN_RMW;
      16'd150: begin dec_fn = FN_RANGE_WR; dec_ascii = 1'b1; dec_np = 3'd1; end
      16'd151: begin dec_fn = FN_RANGE_RD; dec_ascii = 1'b1; dec_np = 3'd1; end
      16'd152: begin dec_fn = FN_RMW;      dec_ascii = 1'b1; dec_np = 3'd1; end
      16'd501: dec_fn = FN_TYPED_RD2;
      16'd502: begin dec_fn = FN_TYPED_RD3; dec_np = 3'd4; end
      16'd509: dec_fn = FN_TYPED_WR2;
      16'd510: begin dec_fn = FN_TYPED_WR3; dec_np = 3'd4; end
      16'd511: begin dec_fn = FN_TYPED_WRM; dec_np = 3'd4; end
      default: begin dec_known = 1'b0; dec_has_fn = 1'b0; dec_np = 3'd0; end
    endcase
  end

  // ****************************************************************
  // decoded command outputs
  // ****************************************************************
  // swap codes are passed on as written; zero for codes 3, 4, 102, 152
  // and 511 is the record author's duty and is not checked here
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_cmd_busy              <= 1'b0;
      o_cmd_done              <= 1'b0;
      o_cmd_error             <= 1'b0;
      o_cmd_enable            <= 1'b0;
      o_cmd_db_addr           <= 16'h0000;
      o_cmd_poll_tenths       <= 20'h00000;
      o_cmd_count             <= 16'h0000;
      o_cmd_swap              <= 16'h0000;
      o_cmd_node              <= 8'h00;
      o_cmd_function_selector <= 16'h0000;
      o_cmd_command           <= 8'h00;
      o_cmd_function          <= 8'h00;
      o_cmd_has_function      <= 1'b0;
      o_cmd_ascii_addr        <= 1'b0;
      o_cmd_param_count       <= 3'd0;
      o_cmd_params            <= '0;
    end else begin
      o_cmd_busy <= (state == SMCT_IDLE) ? (i_cmd_start && !index_bad)
                                         : (state != SMCT_DECODE);
      o_cmd_done  <= 1'b0;
      o_cmd_error <= 1'b0;
      if (state == SMCT_IDLE && i_cmd_start && index_bad) begin
        o_cmd_done   <= 1'b1;
        o_cmd_error  <= 1'b1;
        o_cmd_enable <= 1'b0;
      end
      if (state == SMCT_DECODE) begin
        o_cmd_done              <= 1'b1;
        o_cmd_error             <= !dec_known;
        o_cmd_enable            <= dec_known && (rec[F_ENABLE] != 16'h0000);
        o_cmd_db_addr           <= rec[F_ADDR];
        o_cmd_poll_tenths       <= dec_ascii ? {4'h0, rec[F_POLL]}
                                             : 20'(rec[F_POLL] * TENTHS_PER_SEC);
        o_cmd_count             <= rec[F_COUNT];
        o_cmd_swap              <= rec[F_SWAP];
        o_cmd_node              <= rec[F_NODE][7:0];
        o_cmd_function_selector <= rec[F_FUNC];
        o_cmd_command           <= dec_cmd;
        o_cmd_function          <= dec_fn;
        o_cmd_has_function      <= dec_has_fn;
        o_cmd_ascii_addr        <= dec_ascii;
        o_cmd_param_count       <= dec_np;
        o_cmd_params            <= {rec[F_PARAM0 + 3], rec[F_PARAM0 + 2],
                                    rec[F_PARAM0 + 1], rec[F_PARAM0]};
      end
    end
  end

endmodule : smct_table

// ===== src/smct_pkg.sv
// shared constants for the serial master command table
package smct_pkg;
  // ****************************************************************
  // database layout (word addresses)
  // ****************************************************************
  localparam int unsigned DB_WORDS           = 10000;
  localparam int unsigned DB_AW              = 14;
  localparam int unsigned DW                 = 16;
  localparam int unsigned USER_FIRST         = 0;
  localparam int unsigned USER_LAST          = 4999;
  localparam int unsigned BPCFG_FIRST        = 5000;
  localparam int unsigned BPCFG_LAST         = 5009;
  localparam int unsigned P1CFG_FIRST        = 5010;
  localparam int unsigned P1CFG_LAST         = 5039;
  localparam int unsigned P2CFG_FIRST        = 5040;
  localparam int unsigned P2CFG_LAST         = 5069;
  localparam int unsigned RSV1_FIRST         = 5070;
  localparam int unsigned RSV1_LAST          = 5199;
  localparam int unsigned P1CMD_FIRST        = 5200;
  localparam int unsigned P1CMD_LAST         = 6399;
  localparam int unsigned P2CMD_FIRST        = 6400;
  localparam int unsigned P2CMD_LAST         = 7599;
  localparam int unsigned CMD_LIST_WORDS     = 1200;
  localparam int unsigned STAT_FIRST         = 7600;
  localparam int unsigned STAT_LAST          = 7699;
  localparam int unsigned CTRL_FIRST         = 7800;
  localparam int unsigned CTRL_LAST          = 7999;
  localparam int unsigned P1MAP_FIRST        = 8000;
  localparam int unsigned P1MAP_LAST         = 8199;
  localparam int unsigned P2MAP_FIRST        = 8200;
  localparam int unsigned P2MAP_LAST         = 8399;
  localparam int unsigned RSV2_FIRST         = 8400;
  localparam int unsigned FILE_WORDS         = 200;
  localparam int unsigned FIRST_INTEGER_FILE = 7;
  // first_integer_file_start / configuration_file_start as word addresses
  localparam int unsigned FIRST_INTEGER_FILE_START = 0;
  localparam int unsigned CONFIGURATION_FILE_START = 5000;

  // ****************************************************************
  // command record layout
  // ****************************************************************
  localparam int unsigned REC_WORDS   = 12;
  localparam int unsigned REC_FIELDS  = 11;
  localparam int unsigned REC_COUNT   = CMD_LIST_WORDS / REC_WORDS;
  localparam int unsigned F_ENABLE    = 0;
  localparam int unsigned F_ADDR      = 1;
  localparam int unsigned F_POLL      = 2;
  localparam int unsigned F_COUNT     = 3;
  localparam int unsigned F_SWAP      = 4;
  localparam int unsigned F_NODE      = 5;
  localparam int unsigned F_FUNC      = 6;
  localparam int unsigned F_PARAM0    = 7;
  localparam int unsigned TENTHS_PER_SEC = 10;

  // ****************************************************************
  // protocol command and function bytes
  // ****************************************************************
  localparam logic [7:0] CMD_PROT_WR     = 8'h00;
  localparam logic [7:0] CMD_UNPROT_RD   = 8'h01;
  localparam logic [7:0] CMD_PROT_BITWR  = 8'h02;
  localparam logic [7:0] CMD_UNPROT_BITWR= 8'h05;
  localparam logic [7:0] CMD_UNPROT_WR   = 8'h08;
  localparam logic [7:0] CMD_EXTENDED    = 8'h0f;
  localparam logic [7:0] FN_RANGE_WR     = 8'h00;
  localparam logic [7:0] FN_RANGE_RD     = 8'h01;
  localparam logic [7:0] FN_RMW          = 8'h26;
  localparam logic [7:0] FN_TYPED_RD2    = 8'ha1;
  localparam logic [7:0] FN_TYPED_RD3    = 8'ha2;
  localparam logic [7:0] FN_TYPED_WR2    = 8'ha9;
  localparam logic [7:0] FN_TYPED_WR3    = 8'haa;
  localparam logic [7:0] FN_TYPED_WRM    = 8'hab;
endpackage : smct_pkg

// ===== dv/smct_table_monitor.sv
// port assertions for the serial master command table
`timescale 1ns/1ps
module smct_table_monitor
  import smct_pkg::*;
(
  input wire logic             i_clk,
  input wire logic             i_reset_n,
  input wire logic             i_host_wr,
  input wire logic             i_host_rd,
  input wire logic [DB_AW-1:0] i_host_addr,
  input wire logic             i_link_wr,
  input wire logic             i_link_rd,
  input wire logic [DB_AW-1:0] i_link_addr,
  input wire logic [DW-1:0]    o_host_rdata,
  input wire logic             o_host_rvalid,
  input wire logic             o_host_err,
  input wire logic             o_link_rvalid,
  input wire logic             o_link_err,
  input wire logic             o_cmd_busy,
  input wire logic             o_cmd_done,
  input wire logic             o_cmd_error,
  input wire logic             o_cmd_enable,
  input wire logic [DW-1:0]    o_cmd_function_selector,
  input wire logic [7:0]       o_cmd_command,
  input wire logic             o_cmd_has_function,
  input wire logic             o_cmd_ascii_addr,
  input wire logic [2:0]       o_cmd_param_count
);
  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic host_rsv;
  logic rd_only;
  assign host_rsv = (i_host_addr >= RSV1_FIRST && i_host_addr <= RSV1_LAST) ||
                    (i_host_addr > STAT_LAST && i_host_addr < CTRL_FIRST) ||
                    (i_host_addr >= RSV2_FIRST);
  assign rd_only = i_host_rd && !i_host_wr;
  chk_rsv_read: assert property (rd_only && host_rsv |=> o_host_err && o_host_rdata == 16'h0000)
    else $error("reserved read not refused");
  chk_user_read: assert property (rd_only && i_host_addr <= USER_LAST |=> o_host_rvalid && !o_host_err)
    else $error("user data read refused");
  chk_link_range: assert property ((i_link_wr || i_link_rd) && i_link_addr > USER_LAST |=> o_link_err)
    else $error("link access outside user data accepted");
  chk_link_read: assert property (i_link_rd && !i_link_wr && i_link_addr <= USER_LAST |=> o_link_rvalid)
    else $error("payload read not answered");
  chk_fetch_time: assert property ($rose(o_cmd_busy) |-> o_cmd_busy[*8] ##6 (o_cmd_done && !o_cmd_busy))
    else $error("record decode latency wrong");
  chk_error_done: assert property (o_cmd_error |-> o_cmd_done && !o_cmd_enable)
    else $error("rejected record still enabled");
  chk_ext_bytes: assert property (o_cmd_done && o_cmd_has_function |-> o_cmd_command == CMD_EXTENDED)
    else $error("function byte without extended command");
  chk_ascii_codes: assert property (o_cmd_done && !o_cmd_error |->
      o_cmd_ascii_addr == (o_cmd_function_selector inside {16'd150, 16'd151, 16'd152}))
    else $error("ascii addressing flag wrong");
  chk_basic_form: assert property (o_cmd_done && !o_cmd_error && o_cmd_function_selector inside
      {[16'd1:16'd5]} |-> !o_cmd_has_function && o_cmd_param_count == 3'h1)
    else $error("basic command shape wrong");
endmodule : smct_table_monitor

bind smct_table smct_table_monitor i_mon (.i_clk, .i_reset_n, .i_host_wr, .i_host_rd,
  .i_host_addr, .i_link_wr, .i_link_rd, .i_link_addr, .o_host_rdata, .o_host_rvalid,
  .o_host_err, .o_link_rvalid, .o_link_err, .o_cmd_busy, .o_cmd_done, .o_cmd_error,
  .o_cmd_enable, .o_cmd_function_selector, .o_cmd_command, .o_cmd_has_function,
  .o_cmd_ascii_addr, .o_cmd_param_count);

// ===== dv/smct_slave_model.sv
// remote slave node model on the master data path
`timescale 1ns/1ps
module smct_slave_model (
  input  wire logic        i_clk,
  output logic             o_link_wr,
  output logic             o_link_rd,
  output logic [13:0]      o_link_addr,
  output logic [15:0]      o_link_wdata,
  input  wire logic [15:0] i_link_rdata,
  input  wire logic        i_link_rvalid,
  input  wire logic        i_link_err
);
  initial begin
    o_link_wr = 1'b0;
    o_link_rd = 1'b0;
    o_link_addr = 14'h0000;
    o_link_wdata = 16'h0000;
  end
  // one word per call; released lines flip so stale values never look valid
  task automatic xfer(input logic wr, input logic [13:0] a, inout logic [15:0] d,
                      output logic e, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_link_wr <= wr;
    o_link_rd <= !wr;
    o_link_addr <= a;
    o_link_wdata <= d;
    @(posedge i_clk);
    o_link_wr <= 1'b0;
    o_link_rd <= 1'b0;
    o_link_addr <= ~a;
    o_link_wdata <= ~d;
    #1;
    e = i_link_err;
    if (!wr && i_link_rvalid)
      d = i_link_rdata;
  endtask : xfer
endmodule : smct_slave_model

// ===== dv/smct_table_bench.sv
// self-checking bench for the serial master command table
`timescale 1ns/1ps
module smct_table_bench;
  import smct_pkg::*;
  logic i_clk, i_reset_n, i_host_wr, i_host_rd, i_cmd_start, i_cmd_port;
  logic i_link_wr, i_link_rd, o_host_rvalid, o_host_err, o_link_rvalid, o_link_err;
  logic o_cmd_busy, o_cmd_done, o_cmd_error, o_cmd_enable, o_cmd_has_function;
  logic o_cmd_ascii_addr;
  logic [13:0] i_host_addr, i_link_addr;
  logic [15:0] i_host_wdata, i_link_wdata, o_host_rdata, o_link_rdata, o_cmd_db_addr;
  logic [15:0] o_cmd_count, o_cmd_swap, o_cmd_function_selector;
  logic [7:0]  i_cmd_index, o_cmd_node, o_cmd_command, o_cmd_function;
  logic [19:0] o_cmd_poll_tenths;
  logic [2:0]  o_cmd_param_count;
  logic [63:0] o_cmd_params;
  int          seed = 26157;
  int          errors = 0;
  int          comparisons = 0;
  int          codes[18] = '{1, 2, 3, 4, 5, 100, 101, 102, 150, 151, 152,
                             501, 502, 509, 510, 511, 7, 503};
  logic [13:0] map[17] = '{0, 4999, 5000, 5069, 5070, 5199, 5200, 7599, 7600,
                           7699, 7700, 7799, 7800, 8399, 8400, 9999, 14'h3fff};

  smct_table i_dut (.i_clk, .i_reset_n, .i_host_wr, .i_host_rd, .i_host_addr, .i_host_wdata,
    .o_host_rdata, .o_host_rvalid, .o_host_err, .i_link_wr, .i_link_rd, .i_link_addr,
    .i_link_wdata, .o_link_rdata, .o_link_rvalid, .o_link_err, .i_cmd_start, .i_cmd_port,
    .i_cmd_index(i_cmd_index[6:0]), .o_cmd_busy, .o_cmd_done, .o_cmd_error, .o_cmd_enable,
    .o_cmd_db_addr, .o_cmd_poll_tenths, .o_cmd_count, .o_cmd_swap, .o_cmd_node,
    .o_cmd_function_selector, .o_cmd_command, .o_cmd_function, .o_cmd_has_function,
    .o_cmd_ascii_addr, .o_cmd_param_count, .o_cmd_params);
  smct_slave_model i_slave (.i_clk, .o_link_wr(i_link_wr), .o_link_rd(i_link_rd),
    .o_link_addr(i_link_addr), .o_link_wdata(i_link_wdata), .i_link_rdata(o_link_rdata),
    .i_link_rvalid(o_link_rvalid), .i_link_err(o_link_err));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic host_wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_host_wr <= 1'b1;
    i_host_addr <= a;
    i_host_wdata <= d;
    @(posedge i_clk);
    i_host_wr <= 1'b0;
  endtask : host_wr
  task automatic host_rd(input logic [13:0] a, output logic [16:0] r);
    @(posedge i_clk);
    i_host_rd <= 1'b1;
    i_host_addr <= a;
    @(posedge i_clk);
    i_host_rd <= 1'b0;
    #1;
    r = {o_host_err, o_host_rdata};
  endtask : host_rd
  // an index past the last record is refused in one cycle and never enabled
  task automatic bad_idx;
    @(posedge i_clk);
    i_cmd_start <= 1'b1;
    i_cmd_index <= 8'h64 + 8'($unsigned($random(seed)) % 28);
    @(posedge i_clk);
    i_cmd_start <= 1'b0;
    #1;
    check({o_cmd_done, o_cmd_error, o_cmd_enable, o_cmd_busy}, 4'hc);
  endtask : bad_idx
  // {command, function, known, has_function, ascii, param_count}
  function automatic logic [21:0] exp_dec(input int fc);
    case (fc)
      1: return {CMD_PROT_WR, 8'h00, 3'b100, 3'h1};
      2: return {CMD_UNPROT_RD, 8'h00, 3'b100, 3'h1};
      3: return {CMD_PROT_BITWR, 8'h00, 3'b100, 3'h1};
      4: return {CMD_UNPROT_BITWR, 8'h00, 3'b100, 3'h1};
      5: return {CMD_UNPROT_WR, 8'h00, 3'b100, 3'h1};
      100, 150: return {CMD_EXTENDED, FN_RANGE_WR, 2'b11, fc == 150, fc == 150 ? 3'h1 : 3'h3};
      101, 151: return {CMD_EXTENDED, FN_RANGE_RD, 2'b11, fc == 151, fc == 151 ? 3'h1 : 3'h3};
      102, 152: return {CMD_EXTENDED, FN_RMW, 2'b11, fc == 152, fc == 152 ? 3'h1 : 3'h3};
      501: return {CMD_EXTENDED, FN_TYPED_RD2, 3'b110, 3'h3};
      502: return {CMD_EXTENDED, FN_TYPED_RD3, 3'b110, 3'h4};
      509: return {CMD_EXTENDED, FN_TYPED_WR2, 3'b110, 3'h3};
      510: return {CMD_EXTENDED, FN_TYPED_WR3, 3'b110, 3'h4};
      511: return {CMD_EXTENDED, FN_TYPED_WRM, 3'b110, 3'h4};
      default: return 22'h0;
    endcase
  endfunction : exp_dec
  task automatic run_cmd(input int fc);
    logic [15:0] w[12];
    logic [21:0] e;
    logic [6:0]  idx;
    logic        p;
    int          n;
    idx = 7'($unsigned($random(seed)) % 100);
    p = 1'($random(seed));
    for (int k = 0; k < 12; k++)
      w[k] = 16'($random(seed));
    w[F_ENABLE] = {15'h0000, w[F_ENABLE][0]};
    w[F_POLL] = {8'h00, w[F_POLL][7:0]};
    w[F_FUNC] = 16'(fc);
    if (fc inside {3, 4, 102, 152, 511})
      w[F_SWAP] = 16'h0000;
    for (int k = 0; k < 12; k++)
      host_wr(14'((p ? P2CMD_FIRST : P1CMD_FIRST) + idx * REC_WORDS + k), w[k]);
    @(posedge i_clk);
    i_cmd_start <= 1'b1;
    i_cmd_port <= p;
    i_cmd_index <= {1'b0, idx};
    @(posedge i_clk);
    i_cmd_start <= 1'b0;
    for (n = 0; n < 40 && o_cmd_done !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    e = exp_dec(fc);
    check(n, 13);
    check(o_cmd_error, !e[5]);
    if (e[5]) begin
      check({o_cmd_command, o_cmd_has_function ? o_cmd_function : 8'h00, 1'b1,
             o_cmd_has_function, o_cmd_ascii_addr, o_cmd_param_count}, e);
      check({o_cmd_enable, o_cmd_db_addr, o_cmd_count, o_cmd_swap, o_cmd_node},
            {w[0][0], w[1], w[3], w[4], w[5][7:0]});
      check(o_cmd_function_selector, w[6]);
      check(o_cmd_params, {w[10], w[9], w[8], w[7]});
      check(o_cmd_poll_tenths, fc inside {150, 151, 152} ? 20'(w[2]) : 20'(w[2]) * 10);
    end
    else
      check(o_cmd_enable, 1'b0);
  endtask : run_cmd

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #400000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    logic [16:0] r;
    logic [15:0] d;
    logic [13:0] a;
    logic        er;
    {i_reset_n, i_host_wr, i_host_rd, i_cmd_start, i_cmd_port} = 5'h00;
    {i_host_addr, i_host_wdata, i_cmd_index} = 38'h0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    foreach (map[k]) begin
      d = 16'($random(seed));
      host_wr(map[k], d);
      host_rd(map[k], r);
      // reserved or unmapped words read 0 with an error flag
      check(r, ((map[k] >= 5070 && map[k] <= 5199) || (map[k] >= 7700 && map[k] <= 7799) ||
                map[k] >= 8400) ? 17'h10000 : {1'b0, d});
    end
    $display("map test done");
    for (int k = 0; k < 6; k++) begin
      a = 14'($unsigned($random(seed)) % 5000);
      d = 16'($random(seed));
      i_slave.xfer(1'b1, a, d, er, k);
      host_rd(a, r);
      check({er, r}, {2'b00, d});
      host_wr(a, ~d);
      i_slave.xfer(1'b0, a, d, er, 5 - k);
      check({er, d}, {1'b0, r[15:0] ^ 16'hffff});
    end
    i_slave.xfer(1'b0, 14'd5000, d, er, 0);
    check(er, 1'b1);
    // host write and link write in one cycle: host data lands, link is flagged
    fork
      host_wr(a, ~d);
      i_slave.xfer(1'b1, a, d, er, 0);
    join
    host_rd(a, r);
    check({er, r}, {2'b10, ~d});
    $display("link test done");
    foreach (codes[k]) begin
      run_cmd(codes[k]);
      bad_idx();
    end
    $display("command test done");
    complete_run();
  end
endmodule : smct_table_bench
